// file: rtl/kwp_ports.v
/*
 Key wake-up ports G and H: data, direction, wake enable and write-one-
 to-clear flag registers, falling-edge and start-condition detection,
 stop-mode majority filter with its own oscillator input.
 Assumes a one-cycle register port, pads outside that resolve the
 three-signal pins, and a filter oscillator clock handed in as a level.
*/
`timescale 1ns/1ps
`include "kwp_defines.vh"

// Functional notes
// - Wake-up events on port G and H pins are detected on falling edges.
// - Interrupt requested when any flag and its enable are both set.
// - All wake-up pins merge into one shared interrupt request.
// - Edge detection works whether a pin is input or output.
// - In stop mode the enabled pin path to request is unclocked.
// - Pull-ups when the port pull-select pin is high, else pull-downs.
// - Direction 0 is input, 1 output; H resets to 0; always accessible.
// - Port data registers are writable at any time; reading one returns the synchronised pin level.
// - Select 0: G6 plain falling edge; select 1: G7/G6 start detect.
// - With select set, G6 and G7 drive open-drain.
// - With select set, SDA falling edge counts only while SCL is high.
// - G6 enable and flag follow the selected event type.
// - Enable bits: 0 disables, 1 enables the pin interrupt.
// - Flags set by falling edges; writing one clears a flag.
// - Port G flag bit 7 always reads zero.
// - Glitch filter active only in stop mode, rejecting short pulses.
// - Filter oscillator starts on a triggering edge of an enabled input.
// - Three samples per filter period; two at trigger level validate.
// - One filter serves all inputs with their enable set.
module kwp_ports #(
    parameter WIDTH = 8
) (
    input wire clock_in,
    input wire nrst_in,
    input wire [`KWP_ADDR_W-1:0] addr_in,
    input wire [WIDTH-1:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [WIDTH-1:0] rdata_out,
    input wire [WIDTH-1:0] g_pin_in,
    output wire [WIDTH-1:0] g_pin_out,
    output wire [WIDTH-1:0] g_pin_oe_out,
    input wire [WIDTH-1:0] h_pin_in,
    output wire [WIDTH-1:0] h_pin_out,
    output wire [WIDTH-1:0] h_pin_oe_out,
    input wire g_pull_select_pin_in,
    input wire h_pull_select_pin_in,
    output wire [WIDTH-1:0] g_pull_up_out,
    output wire [WIDTH-1:0] g_pull_down_out,
    output wire [WIDTH-1:0] h_pull_up_out,
    output wire [WIDTH-1:0] h_pull_down_out,
    input wire stop_mode_in,
    input wire filter_osc_in,
    output wire filter_osc_run_out,
    output wire wake_irq_out
);

    reg [WIDTH-1:0] g_data_reg_q;
    reg [WIDTH-1:0] h_data_reg_q;
    reg [WIDTH-1:0] g_direction_reg_q;
    reg [WIDTH-1:0] h_direction_reg_q;
    reg [WIDTH-1:0] g_wake_enable_reg_q;
    reg [WIDTH-1:0] h_wake_enable_reg_q;
    reg [WIDTH-1:0] g_wake_flag_reg_q;
    reg [WIDTH-1:0] h_wake_flag_reg_q;
    wire [WIDTH-1:0] g_wake_flag_reg_d;
    wire [WIDTH-1:0] h_wake_flag_reg_d;

    // Pin synchronisers, three stages each
    reg [WIDTH-1:0] g_s1_q;
    reg [WIDTH-1:0] g_s2_q;
    reg [WIDTH-1:0] g_s3_q;
    reg [WIDTH-1:0] g_lvl_q;
    reg [WIDTH-1:0] h_s1_q;
    reg [WIDTH-1:0] h_s2_q;
    reg [WIDTH-1:0] h_s3_q;
    reg [WIDTH-1:0] h_lvl_q;
    reg osc_s1_q;
    reg osc_s2_q;
    reg osc_s3_q;
    reg osc_lvl_q;

    // Filter state
    reg filt_run_q;
    reg [`KWP_VOTE_CNT_W-1:0] samp_cnt_q;
    reg [`KWP_VOTE_CNT_W-1:0] hit_cnt_q;
    reg [WIDTH-1:0] g_pend_q;
    reg [WIDTH-1:0] h_pend_q;

    wire start_detect_select;
    wire [WIDTH-1:0] g_lvl_d;
    wire [WIDTH-1:0] h_lvl_d;
    wire [WIDTH-1:0] g_fall;
    wire [WIDTH-1:0] h_fall;
    wire [WIDTH-1:0] g_event;
    wire [WIDTH-1:0] g_en_mask;
    wire [WIDTH-1:0] h_en_mask;
    wire any_low;
    wire any_trig;
    wire osc_tick;
    wire vote_done;
    wire vote_ok;
    wire [WIDTH-1:0] g_set;
    wire [WIDTH-1:0] h_set;
    wire g_wr_flag;
    wire h_wr_flag;
    wire raw_wake;
    wire [WIDTH-1:0] g_od;
    wire g_raw;
    wire h_raw;
    wire g_req;
    wire h_req;

    assign start_detect_select = g_wake_enable_reg_q[`KWP_BIT_SEL];

    // A change counts once stages two and three agree
    assign g_lvl_d = (g_s2_q & g_s3_q) | (g_lvl_q & (g_s2_q | g_s3_q));
    assign h_lvl_d = (h_s2_q & h_s3_q) | (h_lvl_q & (h_s2_q | h_s3_q));

    // Edges seen on the pin level, direction ignored
    assign g_fall = g_lvl_q & ~g_lvl_d;
    assign h_fall = h_lvl_q & ~h_lvl_d;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_evt
            if (i == `KWP_BIT_SDA)
            begin : g_sda
                // SDA fall qualified by SCL high
                assign g_event[i] = g_fall[i] &
                    (~start_detect_select | g_lvl_q[`KWP_BIT_SCL]);
                assign g_od[i] = start_detect_select;
            end
            else if (i == `KWP_BIT_SCL)
            begin : g_scl
                assign g_event[i] = 1'b0;
                assign g_od[i] = start_detect_select;
            end
            else
            begin : g_plain
                assign g_event[i] = g_fall[i];
                assign g_od[i] = 1'b0;
            end
        end
    endgenerate

    assign g_en_mask = g_wake_enable_reg_q & `KWP_G_FLAG_MASK;
    assign h_en_mask = h_wake_enable_reg_q;

    // Filter sees any enabled input at trigger level
    assign any_low = |(g_en_mask & ~g_lvl_q) | |(h_en_mask & ~h_lvl_q);
    assign any_trig = |(g_en_mask & g_event) | |(h_en_mask & h_fall);

    // Oscillator runs from a trigger edge until the vote ends
    assign filter_osc_run_out = filt_run_q;
    // Oscillator rise once stages two and three agree high
    assign osc_tick = ~osc_lvl_q & osc_s2_q & osc_s3_q;
    assign vote_done = filt_run_q & osc_tick &
        (samp_cnt_q == `KWP_VOTE_SAMPLES - 2'h1);
    // Majority of three samples
    assign vote_ok = (hit_cnt_q + {1'b0, any_low}) >= `KWP_VOTE_NEED;

    // Filter used only in stop mode
    assign g_set = stop_mode_in ?
        ((vote_done & vote_ok) ? g_pend_q : {WIDTH{1'b0}}) : g_event;
    assign h_set = stop_mode_in ?
        ((vote_done & vote_ok) ? h_pend_q : {WIDTH{1'b0}}) : h_fall;

    assign g_wr_flag = wr_in & (addr_in == `KWP_OFS_G_FLAG);
    assign h_wr_flag = wr_in & (addr_in == `KWP_OFS_H_FLAG);

    // Per-bit flag update: write one clears, a new edge wins
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_flag
            wire g_clr;
            wire h_clr;
            // Write-one strobes for this bit
            assign g_clr = g_wr_flag & wdata_in[i];
            assign h_clr = h_wr_flag & wdata_in[i];
            if (i == `KWP_BIT_SCL)
            begin : g_top
                // Port G bit 7 never holds a flag
                assign g_wake_flag_reg_d[i] = 1'b0;
            end
            else
            begin : g_low
                assign g_wake_flag_reg_d[i] = g_set[i] |
                    (g_wake_flag_reg_q[i] & ~g_clr);
            end
            assign h_wake_flag_reg_d[i] = h_set[i] |
                (h_wake_flag_reg_q[i] & ~h_clr);
        end
    endgenerate

    always @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            g_s1_q <= {WIDTH{1'b1}};
            g_s2_q <= {WIDTH{1'b1}};
            g_s3_q <= {WIDTH{1'b1}};
            g_lvl_q <= {WIDTH{1'b1}};
            h_s1_q <= {WIDTH{1'b1}};
            h_s2_q <= {WIDTH{1'b1}};
            h_s3_q <= {WIDTH{1'b1}};
            h_lvl_q <= {WIDTH{1'b1}};
        end
        else
        begin
            g_s1_q <= g_pin_in;
            g_s2_q <= g_s1_q;
            g_s3_q <= g_s2_q;
            g_lvl_q <= g_lvl_d;
            h_s1_q <= h_pin_in;
            h_s2_q <= h_s1_q;
            h_s3_q <= h_s2_q;
            h_lvl_q <= h_lvl_d;
        end
    end

    // Filter oscillator synchroniser, three stages
    always @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
            osc_lvl_q <= 1'b0;
        end
        else
        begin
            osc_s1_q <= filter_osc_in;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
            osc_lvl_q <= (osc_s2_q & osc_s3_q) |
                (osc_lvl_q & (osc_s2_q | osc_s3_q));
        end
    end

    // Majority-vote filter sequencing
    always @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            filt_run_q <= 1'b0;
            samp_cnt_q <= {`KWP_VOTE_CNT_W{1'b0}};
            hit_cnt_q <= {`KWP_VOTE_CNT_W{1'b0}};
            g_pend_q <= {WIDTH{1'b0}};
            h_pend_q <= {WIDTH{1'b0}};
        end
        else if (!stop_mode_in)
        begin
            filt_run_q <= 1'b0;
            samp_cnt_q <= {`KWP_VOTE_CNT_W{1'b0}};
            hit_cnt_q <= {`KWP_VOTE_CNT_W{1'b0}};
            g_pend_q <= {WIDTH{1'b0}};
            h_pend_q <= {WIDTH{1'b0}};
        end
        else if (!filt_run_q)
        begin
            if (any_trig)
            begin
                filt_run_q <= 1'b1;
                g_pend_q <= g_en_mask & g_event;
                h_pend_q <= h_en_mask & h_fall;
            end
        end
        else
        begin
            g_pend_q <= g_pend_q | (g_en_mask & g_event);
            h_pend_q <= h_pend_q | (h_en_mask & h_fall);
            if (vote_done)
            begin
                // Period over, rearm on the next edge
                samp_cnt_q <= {`KWP_VOTE_CNT_W{1'b0}};
                hit_cnt_q <= {`KWP_VOTE_CNT_W{1'b0}};
                filt_run_q <= 1'b0;
                if (!vote_ok)
                begin
                    // Short pulse rejected, pending bits dropped
                    g_pend_q <= {WIDTH{1'b0}};
                    h_pend_q <= {WIDTH{1'b0}};
                end
            end
            else if (osc_tick)
            begin
                samp_cnt_q <= samp_cnt_q + 2'h1;
                hit_cnt_q <= hit_cnt_q + {1'b0, any_low};
            end
        end
    end

    // Register file, always accessible
    always @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            g_data_reg_q <= `KWP_RST_BYTE;
            h_data_reg_q <= `KWP_RST_BYTE;
            g_direction_reg_q <= `KWP_RST_BYTE;
            h_direction_reg_q <= `KWP_RST_BYTE;
            g_wake_enable_reg_q <= `KWP_RST_BYTE;
            h_wake_enable_reg_q <= `KWP_RST_BYTE;
            g_wake_flag_reg_q <= `KWP_RST_BYTE;
            h_wake_flag_reg_q <= `KWP_RST_BYTE;
            rdata_out <= `KWP_RST_BYTE;
        end
        else
        begin
            g_wake_flag_reg_q <= g_wake_flag_reg_d;
            h_wake_flag_reg_q <= h_wake_flag_reg_d;
            if (wr_in)
            begin
                case (addr_in)
                    `KWP_OFS_G_DATA: g_data_reg_q <= wdata_in;
                    `KWP_OFS_H_DATA: h_data_reg_q <= wdata_in;
                    `KWP_OFS_G_DIR: g_direction_reg_q <= wdata_in;
                    `KWP_OFS_H_DIR: h_direction_reg_q <= wdata_in;
                    `KWP_OFS_G_EN: g_wake_enable_reg_q <= wdata_in;
                    `KWP_OFS_H_EN: h_wake_enable_reg_q <= wdata_in;
                    default: g_data_reg_q <= g_data_reg_q;
                endcase
            end
            if (rd_in)
            begin
                case (addr_in)
                    `KWP_OFS_G_DATA: rdata_out <= g_lvl_q;
                    `KWP_OFS_H_DATA: rdata_out <= h_lvl_q;
                    `KWP_OFS_G_DIR: rdata_out <= g_direction_reg_q;
                    `KWP_OFS_H_DIR: rdata_out <= h_direction_reg_q;
                    `KWP_OFS_G_EN: rdata_out <= g_wake_enable_reg_q;
                    `KWP_OFS_H_EN: rdata_out <= h_wake_enable_reg_q;
                    `KWP_OFS_G_FLAG: rdata_out <= g_wake_flag_reg_q;
                    `KWP_OFS_H_FLAG: rdata_out <= h_wake_flag_reg_q;
                    default: rdata_out <= `KWP_RST_BYTE;
                endcase
            end
            else
            begin
                rdata_out <= `KWP_RST_BYTE;
            end
        end
    end

    // Open-drain on G6/G7 while start detect is selected
    assign g_pin_out = g_data_reg_q & ~g_od;
    assign g_pin_oe_out = g_direction_reg_q & ~(g_od & g_data_reg_q);
    // Direction 1 drives the pin
    assign h_pin_out = h_data_reg_q;
    assign h_pin_oe_out = h_direction_reg_q;

    // Pull direction from the port pull-select pin
    assign g_pull_up_out = {WIDTH{g_pull_select_pin_in}};
    assign g_pull_down_out = {WIDTH{~g_pull_select_pin_in}};
    assign h_pull_up_out = {WIDTH{h_pull_select_pin_in}};
    assign h_pull_down_out = {WIDTH{~h_pull_select_pin_in}};

    // Unclocked stop-mode path from enabled low pins
    assign g_raw = |(g_en_mask & ~g_pin_in);
    assign h_raw = |(h_en_mask & ~h_pin_in);
    assign raw_wake = stop_mode_in & ~filt_run_q & (g_raw | h_raw);

    // Flags meet their enables per port
    assign g_req = |(g_wake_flag_reg_q & g_en_mask);
    assign h_req = |(h_wake_flag_reg_q & h_en_mask);
    // Single shared request for every wake-up pin
    assign wake_irq_out = g_req | h_req | raw_wake;

endmodule

// file: rtl/kwp_defines.vh
/*
 Register offsets, field positions and reset values for the key wake-up
 ports. Included by the port block; holds definitions only.
*/
`ifndef KWP_DEFINES_VH
`define KWP_DEFINES_VH

`define KWP_ADDR_W 6
`define KWP_OFS_G_DATA 6'h28
`define KWP_OFS_H_DATA 6'h29
`define KWP_OFS_G_DIR 6'h2a
`define KWP_OFS_H_DIR 6'h2b
`define KWP_OFS_G_EN 6'h2c
`define KWP_OFS_H_EN 6'h2d
`define KWP_OFS_G_FLAG 6'h2e
`define KWP_OFS_H_FLAG 6'h2f
`define KWP_RST_BYTE 8'h00
`define KWP_BIT_SDA 6
`define KWP_BIT_SCL 7
`define KWP_BIT_SEL 7
`define KWP_G_FLAG_MASK 8'h7f
`define KWP_VOTE_CNT_W 2
`define KWP_VOTE_SAMPLES 2'h3
`define KWP_VOTE_NEED 2'h2

`endif

// file: bench/kwp_ports_monitor.sv
/*
 Checker for the key wake-up ports: register side, pin drive, pulls,
 shared request and stop filter. Sees only the block's ports; bound below.
*/
`timescale 1ns/1ps
`include "kwp_defines.vh"
module kwp_ports_monitor (
    input wire clock_in,
    input wire nrst_in,
    input wire [`KWP_ADDR_W-1:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [7:0] rdata_out,
    input wire [7:0] g_pin_out,
    input wire [7:0] g_pin_oe_out,
    input wire [7:0] h_pin_in,
    input wire [7:0] h_pin_out,
    input wire [7:0] h_pin_oe_out,
    input wire g_pull_select_pin_in,
    input wire h_pull_select_pin_in,
    input wire [7:0] g_pull_up_out,
    input wire [7:0] g_pull_down_out,
    input wire [7:0] h_pull_up_out,
    input wire [7:0] h_pull_down_out,
    input wire stop_mode_in,
    input wire filter_osc_run_out,
    input wire wake_irq_out
);
    reg [7:0] g_en_q;
    reg [7:0] h_en_q;
    reg [7:0] h_dir_q;
    reg [7:0] h_data_q;
    // Shadow copies of written registers
    always @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            g_en_q <= 8'h00;
            h_en_q <= 8'h00;
            h_dir_q <= 8'h00;
            h_data_q <= 8'h00;
        end
        else if (wr_in)
        begin
            if (addr_in == `KWP_OFS_G_EN) g_en_q <= wdata_in;
            if (addr_in == `KWP_OFS_H_EN) h_en_q <= wdata_in;
            if (addr_in == `KWP_OFS_H_DIR) h_dir_q <= wdata_in;
            if (addr_in == `KWP_OFS_H_DATA) h_data_q <= wdata_in;
        end
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    a_read_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data not idle");
    a_g_flag_top: assert property ($past(rd_in) &&
        $past(addr_in) == `KWP_OFS_G_FLAG |-> !rdata_out[7])
        else $error("port g flag bit 7 set");
    a_h_dir_drive: assert property (h_pin_oe_out == h_dir_q)
        else $error("port h enable differs from direction");
    a_h_data_drive: assert property (h_pin_out == h_data_q)
        else $error("port h drive differs from data");
    a_pull_choice: assert property ((g_pull_select_pin_in ?
        g_pull_down_out : g_pull_up_out) == 8'h00 && (h_pull_select_pin_in ?
        h_pull_down_out : h_pull_up_out) == 8'h00)
        else $error("wrong pull kind");
    a_irq_on_flag: assert property ($past(rd_in) &&
        $past(addr_in) == `KWP_OFS_H_FLAG && (rdata_out & h_en_q) != 8'h00
        |-> wake_irq_out) else $error("enabled flag without request");
    a_irq_masked: assert property (g_en_q[6:0] == 7'h00 &&
        h_en_q == 8'h00 |-> !wake_irq_out) else $error("request while masked");
    a_open_drain: assert property (g_en_q[7] |->
        (g_pin_oe_out[7:6] & g_pin_out[7:6]) == 2'b00)
        else $error("start pins drive high");
    a_filter_stop: assert property (!stop_mode_in [*2]
        |-> !filter_osc_run_out) else $error("filter runs outside stop");
    a_edge_to_irq: assert property ((h_en_q & $past(h_pin_in) & ~h_pin_in)
        != 8'h00 |-> ##[1:6] wake_irq_out) else $error("edge missed");
    c_irq: cover property (wake_irq_out);
    c_stop_run: cover property (stop_mode_in && filter_osc_run_out);
    c_start_irq: cover property (g_en_q[7] && wake_irq_out);
endmodule

bind kwp_ports kwp_ports_monitor i_mon (.clock_in(clock_in),
    .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .g_pin_out(g_pin_out), .g_pin_oe_out(g_pin_oe_out), .h_pin_in(h_pin_in),
    .h_pin_out(h_pin_out), .h_pin_oe_out(h_pin_oe_out),
    .g_pull_select_pin_in(g_pull_select_pin_in),
    .h_pull_select_pin_in(h_pull_select_pin_in),
    .g_pull_up_out(g_pull_up_out), .g_pull_down_out(g_pull_down_out),
    .h_pull_up_out(h_pull_up_out), .h_pull_down_out(h_pull_down_out),
    .stop_mode_in(stop_mode_in), .filter_osc_run_out(filter_osc_run_out),
    .wake_irq_out(wake_irq_out));

// file: bench/kwp_keys.sv
/*
 Key switches and pulls on one 8-pin port, plus the filter oscillator.
 Assumes the block's drive, enable and pull outputs are fed back here.
*/
`timescale 1ns/1ps
module kwp_keys (
    input wire [7:0] oe_in,
    input wire [7:0] drive_in,
    input wire [7:0] key_en_in,
    input wire [7:0] key_val_in,
    input wire [7:0] pull_up_in,
    input wire [7:0] pull_down_in,
    input wire osc_run_in,
    output logic [7:0] pin_out,
    output logic osc_out
);
    logic flt = 1'b0;
    initial osc_out = 1'b0;
    always #35 flt = ~flt;
    // Oscillator stands still unless run is requested
    always #170 osc_out = osc_run_in ? ~osc_out : 1'b0;
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            pin_out[i] = oe_in[i] ? drive_in[i] : key_en_in[i] ?
                key_val_in[i] : pull_up_in[i] ? 1'b1 :
                pull_down_in[i] ? 1'b0 : flt;
    end
endmodule

// file: bench/tb.sv
/*
 Self-checking bench for the key wake-up ports.
 Assumes the bound checker and the key model beside the block.
*/
`timescale 1ns/1ps
`include "kwp_defines.vh"
module tb;
    logic clock_in = 0, nrst_in = 0, wr_in = 0, rd_in = 0, stop_in = 0;
    logic gsel = 1, hsel = 1;
    logic [5:0] addr_in = 0, a;
    logic [7:0] wdata_in = 0, d, gk_en = 0, gk_val = 0, hk_en = 0;
    wire [7:0] g_pin, g_out, g_oe, h_pin, h_out, h_oe, gpu, gpd, hpu, hpd;
    wire [7:0] rdata;
    wire osc, run, irq;
    int num_errors = 0, tests_run = 0, cyc = 0;
    kwp_ports i_dut (.clock_in(clock_in), .nrst_in(nrst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata), .g_pin_in(g_pin), .g_pin_out(g_out),
        .g_pin_oe_out(g_oe), .h_pin_in(h_pin), .h_pin_out(h_out),
        .h_pin_oe_out(h_oe), .g_pull_select_pin_in(gsel),
        .h_pull_select_pin_in(hsel), .g_pull_up_out(gpu),
        .g_pull_down_out(gpd), .h_pull_up_out(hpu), .h_pull_down_out(hpd),
        .stop_mode_in(stop_in), .filter_osc_in(osc),
        .filter_osc_run_out(run), .wake_irq_out(irq));
    kwp_keys i_gk (.oe_in(g_oe), .drive_in(g_out), .key_en_in(gk_en),
        .key_val_in(gk_val), .pull_up_in(gpu), .pull_down_in(gpd),
        .osc_run_in(run), .pin_out(g_pin), .osc_out(osc));
    kwp_keys i_hk (.oe_in(h_oe), .drive_in(h_out), .key_en_in(hk_en),
        .key_val_in(8'h00), .pull_up_in(hpu), .pull_down_in(hpd),
        .osc_run_in(1'b0), .pin_out(h_pin), .osc_out());
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] ad, input logic [7:0] v);
        @(posedge clock_in);
        addr_in <= ad;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] ad, input logic [7:0] e);
        @(posedge clock_in);
        addr_in <= ad;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task tally_and_finish;
        if (num_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        forever #25 clock_in = ~clock_in;
    end
    always @(posedge clock_in)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            num_errors++;
            tally_and_finish;
        end
    end
    initial
    begin
        void'($urandom(33605));
        repeat (5) @(posedge clock_in);
        nrst_in <= 1'b1;
        rd(`KWP_OFS_H_DIR, 8'h00);
        rd(6'h10, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            a = 6'h2a + 6'(i % 4);
            d = 8'($urandom) & (a == `KWP_OFS_G_EN ? 8'h7f : 8'hff);
            wr(a, d);
            rd(a, d);
        end
        for (int i = 0; i < 4; i++)
            wr(6'h2a + 6'(i), 8'h00);
        wr(`KWP_OFS_H_DIR, 8'hff);
        wr(`KWP_OFS_H_EN, 8'hff);
        wr(`KWP_OFS_H_DATA, 8'hff);
        repeat (6) @(posedge clock_in);
        wr(`KWP_OFS_H_FLAG, 8'hff);
        wr(`KWP_OFS_G_FLAG, 8'hff);
        d = 8'($urandom);
        wr(`KWP_OFS_H_DATA, d);
        repeat (6) @(posedge clock_in);
        #1 chk(h_out, d);
        rd(`KWP_OFS_H_DATA, d);
        rd(`KWP_OFS_H_FLAG, ~d);
        chk({7'h00, irq}, {7'h00, |(~d)});
        wr(`KWP_OFS_H_FLAG, 8'hff);
        rd(`KWP_OFS_H_FLAG, 8'h00);
        wr(`KWP_OFS_H_DIR, 8'h00);
        wr(`KWP_OFS_H_EN, 8'h00);
        gk_en <= 8'hff;
        repeat (6) @(posedge clock_in);
        rd(`KWP_OFS_G_FLAG, 8'h7f);
        gk_en <= 8'h00;
        repeat (6) @(posedge clock_in);
        wr(`KWP_OFS_G_FLAG, 8'hff);
        wr(`KWP_OFS_G_DATA, 8'hc0);
        wr(`KWP_OFS_G_DIR, 8'hc0);
        wr(`KWP_OFS_G_EN, 8'hc0);
        gk_en <= 8'h80;
        #1 chk(g_oe, 8'h00);
        repeat (3) @(posedge clock_in);
        gk_en <= 8'hc0;
        repeat (6) @(posedge clock_in);
        rd(`KWP_OFS_G_FLAG, 8'h00);
        gk_en <= 8'h00;
        repeat (6) @(posedge clock_in);
        gk_en <= 8'h40;
        repeat (6) @(posedge clock_in);
        rd(`KWP_OFS_G_FLAG, 8'h40);
        chk({7'h00, irq}, 8'h01);
        gk_en <= 8'h00;
        wr(`KWP_OFS_G_FLAG, 8'hff);
        wr(`KWP_OFS_G_EN, 8'h00);
        wr(`KWP_OFS_H_EN, 8'h04);
        stop_in <= 1'b1;
        @(posedge clock_in);
        hk_en <= 8'h04;
        repeat (2) @(posedge clock_in);
        hk_en <= 8'h00;
        repeat (60) @(posedge clock_in);
        rd(`KWP_OFS_H_FLAG, 8'h00);
        @(posedge clock_in);
        hk_en <= 8'h04;
        #2 chk({7'h00, irq}, 8'h01);
        repeat (100) @(posedge clock_in);
        hk_en <= 8'h00;
        repeat (10) @(posedge clock_in);
        stop_in <= 1'b0;
        rd(`KWP_OFS_H_FLAG, 8'h04);
        wr(`KWP_OFS_H_FLAG, 8'hff);
        wr(`KWP_OFS_H_EN, 8'h00);
        gsel <= 1'b0;
        hsel <= 1'b0;
        repeat (5) @(posedge clock_in);
        tally_and_finish;
    end
endmodule
